// file: hw/lcdc_pkg.sv
// Shared constants and types of the panel controller register bank.
package lcdc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int IDX_W = 5;
    localparam int DATA_W = 32;
    localparam int REG_COUNT = 32;
    localparam logic [16:0] REG_WINDOW_BASE = 17'h1_ffe0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_IDENTITY = 5'h00;
    localparam logic [4:0] IDX_MODE0 = 5'h01;
    localparam logic [4:0] IDX_MODE1 = 5'h02;
    localparam logic [4:0] IDX_POWER = 5'h03;
    localparam logic [4:0] IDX_HSIZE = 5'h04;
    localparam logic [4:0] IDX_VSIZE_LO = 5'h05;
    localparam logic [4:0] IDX_VSIZE_HI = 5'h06;
    localparam logic [4:0] IDX_LINE_START = 5'h07;
    localparam logic [4:0] IDX_HBLANK = 5'h08;
    localparam logic [4:0] IDX_FRAME_START = 5'h09;
    localparam logic [4:0] IDX_VBLANK = 5'h0a;
    localparam logic [4:0] IDX_AC_BIAS = 5'h0b;
    localparam logic [4:0] IDX_S1_START_LO = 5'h0c;
    localparam logic [4:0] IDX_S1_START_HI = 5'h0d;
    localparam logic [4:0] IDX_S2_START_LO = 5'h0e;
    localparam logic [4:0] IDX_S2_START_HI = 5'h0f;
    localparam logic [4:0] IDX_START_OVF = 5'h10;
    localparam logic [4:0] IDX_LINE_OFFSET = 5'h11;
    localparam logic [4:0] IDX_S1_HEIGHT_LO = 5'h12;
    localparam logic [4:0] IDX_S1_HEIGHT_HI = 5'h13;
    localparam logic [4:0] IDX_PAL_INDEX = 5'h15;
    localparam logic [4:0] IDX_PAL_VALUE = 5'h17;
    localparam logic [4:0] IDX_PIN_DIR = 5'h18;
    localparam logic [4:0] IDX_PIN_LEVEL = 5'h19;
    localparam logic [4:0] IDX_SCRATCH = 5'h1a;
    localparam logic [4:0] IDX_BYTES_LINE = 5'h1c;

    // Bit set for every index that answers as a register.
    localparam logic [31:0] REG_MAPPED = 32'h17af_ffff;

    // Writable bits of each register; unused bits stay zero.
    localparam logic [7:0] WR_MASK [REG_COUNT] = '{
        8'h00, 8'hff, 8'hff, 8'h0f, 8'h7f, 8'hff, 8'h03, 8'h1f,
        8'h1f, 8'h3f, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h03, 8'h00, 8'hff, 8'h00, 8'hf0,
        8'h1f, 8'h1f, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00
    };

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int M0_TFT_BIT = 7;
    localparam int M0_DUAL_BIT = 6;
    localparam int M0_COLOR_BIT = 5;
    localparam int M0_LINE_POL_BIT = 4;
    localparam int M0_FRAME_POL_BIT = 3;
    localparam int M0_MASK_SHIFT_BIT = 2;
    localparam int M0_WIDTH_LSB = 0;
    localparam int M1_BPP_LSB = 6;
    localparam int M1_HIGH_PERF_BIT = 5;
    localparam int M1_CLK_DIV_BIT = 4;
    localparam int M1_BLANK_BIT = 3;
    localparam int PW_OVERRIDE_BIT = 3;
    localparam int PW_HW_SAVE_BIT = 2;
    localparam int PW_SW_SAVE_LSB = 0;
    localparam int VBLANK_STATUS_BIT = 7;

    typedef enum logic [3:0] {
        LCDC_FMT_MONO_4,
        LCDC_FMT_MONO_8,
        LCDC_FMT_COLOR_4,
        LCDC_FMT_COLOR_8_F1,
        LCDC_FMT_COLOR_8_F2,
        LCDC_FMT_MONO_DUAL_8,
        LCDC_FMT_COLOR_DUAL_8,
        LCDC_FMT_TFT_9,
        LCDC_FMT_TFT_12,
        LCDC_FMT_RESERVED
    } lcdc_fmt_e;

endpackage

// file: hw/lcdc_mode_decode.sv
// Decoder of the mode and power fields into display settings.
`timescale 1ns/1ps
module lcdc_mode_decode
    import lcdc_pkg::*;
(
    input wire logic [7:0] mode0,
    input wire logic [7:0] mode1,
    input wire logic [7:0] power,
    output logic [3:0] bits_per_pixel,
    output logic depth_reserved,
    output lcdc_fmt_e panel_format,
    output logic [3:0] mclk_divisor,
    output logic power_save_mode1,
    output logic normal_operation
);
    wire tft = mode0[M0_TFT_BIT];
    wire dual = mode0[M0_DUAL_BIT];
    wire color = mode0[M0_COLOR_BIT];
    wire [1:0] width = mode0[M0_WIDTH_LSB +: 2];
    wire [1:0] bpp = mode1[M1_BPP_LSB +: 2];
    wire high_perf = mode1[M1_HIGH_PERF_BIT];
    wire [1:0] sw_save = power[PW_SW_SAVE_LSB +: 2];

    // Depth 1, 2, 4 or 8 bits; mono has no 8-bit mode.
    assign bits_per_pixel = 4'(4'h1 << bpp); // [RL3]
    assign depth_reserved = ~color & (bpp == 2'b11); // [RL3]
    // Memory clock divides down from pixel clock by 8/bpp unless fast.
    assign mclk_divisor = high_perf ? 4'h1 : 4'(4'h8 >> bpp); // [RL11]
    assign power_save_mode1 = (sw_save == 2'b00); // [RL12]
    assign normal_operation = (sw_save == 2'b11); // [RL12]

    always_comb begin
        panel_format = LCDC_FMT_RESERVED;
        if (tft) begin
            panel_format = width[0] ? LCDC_FMT_TFT_12 : LCDC_FMT_TFT_9; // [RL10]
        end else if (dual) begin
            if (width == 2'b01) begin
                panel_format = color ? LCDC_FMT_COLOR_DUAL_8 : LCDC_FMT_MONO_DUAL_8; // [RL9]
            end
        end else if (!color) begin
            if (width == 2'b00) begin
                panel_format = LCDC_FMT_MONO_4; // [RL4]
            end else if (width == 2'b01) begin
                panel_format = LCDC_FMT_MONO_8; // [RL5]
            end
        end else begin
            unique case (width)
                2'b00: panel_format = LCDC_FMT_COLOR_4; // [RL6]
                2'b01: panel_format = LCDC_FMT_COLOR_8_F1; // [RL7]
                2'b11: panel_format = LCDC_FMT_COLOR_8_F2; // [RL8]
                2'b10: panel_format = LCDC_FMT_RESERVED; // [RL8]
            endcase
        end
    end
endmodule

// file: hw/lcdc_config_regs.sv
// Configuration and status register bank of the panel controller.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// How it works
// (RL1) Read-only identity: product and revision code.
// (RL2) Registers decoded at top of memory window.
// (RL3) Colour bit and depth field choose format.
// (RL4) Mono single width 00 gives 4-bit panel.
// (RL5) Mono single width 01 gives 8-bit panel.
// (RL6) Colour single width 00 gives 4-bit panel.
// (RL7) Colour single width 01 gives 8-bit format one.
// (RL8) Colour single width 11 gives 8-bit format two.
// (RL9) Dual drive supports 8-bit colour and mono.
// (RL10) Active panel ignores dual; width bit picks 9/12.
// (RL11) Memory clock divides pixel clock unless fast.
// (RL12) Power field: 00 save mode, 11 normal.
// (RL13) Ten-bit screen height from low and high.
// (RL14) Scratch byte reads back, affects nothing.
// (RL15) Direction bit for each of five pins.
// (RL16) Level register samples inputs, drives outputs.
// (RL17) Line byte count register, read-write.
// (RL18) Palette value: upper nibble kept, lower zero.
module lcdc_config_regs
    import lcdc_pkg::*;
#(
    parameter int GPIO_COUNT = 5,
    parameter logic [5:0] PRODUCT_CODE = 6'h2a, // Arbitrary value.
    parameter logic [1:0] REVISION_CODE = 2'h1 // Arbitrary value.
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic vblank_status,
    input wire logic [GPIO_COUNT-1:0] gpio_in,
    output logic [GPIO_COUNT-1:0] gpio_out,
    output logic [GPIO_COUNT-1:0] gpio_oe,
    output logic [3:0] bits_per_pixel,
    output logic depth_reserved,
    output lcdc_fmt_e panel_format,
    output logic [3:0] mclk_divisor,
    output logic power_save_mode1,
    output logic normal_operation,
    output logic line_pulse_polarity,
    output logic frame_pulse_polarity,
    output logic pixel_shift_clock_mask,
    output logic display_blank,
    output logic panel_power_override,
    output logic [6:0] horizontal_size,
    output logic [9:0] vertical_size,
    output logic [15:0] screen1_start,
    output logic [15:0] screen2_start,
    output logic [7:0] line_offset,
    output logic [9:0] screen1_height,
    output logic [7:0] palette_index,
    output logic [3:0] palette_value,
    output logic [7:0] bytes_per_line
);
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0] regs_reg [REG_COUNT];
    logic wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [3:0] bpp_reg;
    logic depth_rsv_reg;
    lcdc_fmt_e fmt_reg;
    logic [3:0] mdiv_reg;
    logic save1_reg;
    logic normal_reg;

    wire [IDX_W-1:0] idx = avs_address[IDX_W-1:0];
    wire in_window = (avs_address[ADDR_W-1:IDX_W] == REG_WINDOW_BASE[ADDR_W-1:IDX_W]); // [RL2]
    wire mapped = in_window & REG_MAPPED[idx]; // [RL2]
    wire request = avs_read | avs_write;
    wire wr_commit = avs_write & ~wait_reg & mapped & avs_byteenable[0];
    wire [7:0] wdata = avs_writedata[7:0];
    wire [7:0] pin_dir = regs_reg[IDX_PIN_DIR];
    wire [7:0] pin_lvl = regs_reg[IDX_PIN_LEVEL];
    wire [7:0] pin_read = {3'h0, (pin_lvl[GPIO_COUNT-1:0] & pin_dir[GPIO_COUNT-1:0])
        | (gpio_in & ~pin_dir[GPIO_COUNT-1:0])}; // [RL16]
    wire [7:0] id_value = {PRODUCT_CODE, REVISION_CODE}; // [RL1]
    wire [7:0] vblank_read = {vblank_status, regs_reg[IDX_VBLANK][6:0]};

    logic [7:0] reg_read;
    always_comb begin
        reg_read = regs_reg[idx];
        if (idx == IDX_IDENTITY) begin
            reg_read = id_value; // [RL1]
        end else if (idx == IDX_VBLANK) begin
            reg_read = vblank_read;
        end else if (idx == IDX_PIN_LEVEL) begin
            reg_read = pin_read; // [RL16]
        end
    end

    wire [DATA_W-1:0] rd_word = mapped ? {24'h00_0000, reg_read} : '0; // [RL2]
    wire wait_next = ~(request & wait_reg);

    // ------------------------------------------------------------------
    // Bus handshake: one wait state, then a one-cycle answer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= wait_next;
            if (avs_read && wait_reg) begin
                rdata_reg <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Writes touch only the bits that exist; others keep reading zero.
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                regs_reg[i] <= REG_RESET;
            end else if (wr_commit && idx == 5'(i)) begin
                regs_reg[i] <= (regs_reg[i] & ~WR_MASK[i]) | (wdata & WR_MASK[i]); // [RL13] [RL14]
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [3:0] dec_bpp;
    logic dec_depth_rsv;
    lcdc_fmt_e dec_fmt;
    logic [3:0] dec_mdiv;
    logic dec_save1;
    logic dec_normal;

    lcdc_mode_decode u_decode (
        .mode0(regs_reg[IDX_MODE0]),
        .mode1(regs_reg[IDX_MODE1]),
        .power(regs_reg[IDX_POWER]),
        .bits_per_pixel(dec_bpp),
        .depth_reserved(dec_depth_rsv),
        .panel_format(dec_fmt),
        .mclk_divisor(dec_mdiv),
        .power_save_mode1(dec_save1),
        .normal_operation(dec_normal)
    );

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bpp_reg <= 4'h1;
            depth_rsv_reg <= 1'b0;
            fmt_reg <= LCDC_FMT_MONO_4;
            mdiv_reg <= 4'h8;
            save1_reg <= 1'b1;
            normal_reg <= 1'b0;
        end else begin
            bpp_reg <= dec_bpp; // [RL3]
            depth_rsv_reg <= dec_depth_rsv;
            fmt_reg <= dec_fmt; // [RL4] [RL5] [RL6] [RL7] [RL8] [RL9] [RL10]
            mdiv_reg <= dec_mdiv; // [RL11]
            save1_reg <= dec_save1; // [RL12]
            normal_reg <= dec_normal;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign gpio_oe = pin_dir[GPIO_COUNT-1:0]; // [RL15]
    assign gpio_out = pin_lvl[GPIO_COUNT-1:0]; // [RL16]
    assign bits_per_pixel = bpp_reg;
    assign depth_reserved = depth_rsv_reg;
    assign panel_format = fmt_reg;
    assign mclk_divisor = mdiv_reg;
    assign power_save_mode1 = save1_reg;
    assign normal_operation = normal_reg;
    assign line_pulse_polarity = regs_reg[IDX_MODE0][M0_LINE_POL_BIT];
    assign frame_pulse_polarity = regs_reg[IDX_MODE0][M0_FRAME_POL_BIT];
    assign pixel_shift_clock_mask = regs_reg[IDX_MODE0][M0_MASK_SHIFT_BIT];
    assign display_blank = regs_reg[IDX_MODE1][M1_BLANK_BIT];
    assign panel_power_override = regs_reg[IDX_POWER][PW_OVERRIDE_BIT];
    assign horizontal_size = regs_reg[IDX_HSIZE][6:0];
    assign vertical_size = {regs_reg[IDX_VSIZE_HI][1:0], regs_reg[IDX_VSIZE_LO]};
    assign screen1_start = {regs_reg[IDX_S1_START_HI], regs_reg[IDX_S1_START_LO]};
    assign screen2_start = {regs_reg[IDX_S2_START_HI], regs_reg[IDX_S2_START_LO]};
    assign line_offset = regs_reg[IDX_LINE_OFFSET];
    assign screen1_height = {regs_reg[IDX_S1_HEIGHT_HI][1:0], regs_reg[IDX_S1_HEIGHT_LO]}; // [RL13]
    assign palette_index = regs_reg[IDX_PAL_INDEX];
    assign palette_value = regs_reg[IDX_PAL_VALUE][7:4]; // [RL18]
    assign bytes_per_line = regs_reg[IDX_BYTES_LINE]; // [RL17]

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wire rd_done = avs_read & ~wait_reg;
    wire wr_done = avs_write & ~wait_reg & avs_byteenable[0];
    wire at_reg0 = in_window & (idx == IDX_IDENTITY);

    chk_id_value: assert property (@(posedge mclk) disable iff (!resetn) // [RL1]
        rd_done && at_reg0 |-> avs_readdata == {24'h00_0000, id_value})
        else $error("identity read returned a wrong value");

    chk_bus_answer: assert property (@(posedge mclk) disable iff (!resetn) // [RL2]
        request && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("bus answer not after exactly one wait state");

    chk_unmapped_zero: assert property (@(posedge mclk) disable iff (!resetn) // [RL2]
        rd_done && !mapped |-> avs_readdata == '0)
        else $error("unmapped read did not return zero");

    chk_mono_depth: assert property (@(posedge mclk) disable iff (!resetn) // [RL3]
        !regs_reg[IDX_MODE0][M0_COLOR_BIT] && regs_reg[IDX_MODE1][7:6] == 2'b11
        |=> depth_reserved)
        else $error("mono 8-bit depth not flagged reserved");

    chk_fmt_mono4: assert property (@(posedge mclk) disable iff (!resetn) // [RL4]
        regs_reg[IDX_MODE0][7:5] == 3'b000 && regs_reg[IDX_MODE0][1:0] == 2'b00
        |=> panel_format == LCDC_FMT_MONO_4)
        else $error("mono single 4-bit format not selected");

    chk_fmt_color8b: assert property (@(posedge mclk) disable iff (!resetn) // [RL8]
        regs_reg[IDX_MODE0][7:5] == 3'b001 && regs_reg[IDX_MODE0][1:0] == 2'b11
        |=> panel_format == LCDC_FMT_COLOR_8_F2)
        else $error("colour single 8-bit second format not selected");

    chk_fmt_active: assert property (@(posedge mclk) disable iff (!resetn) // [RL10]
        regs_reg[IDX_MODE0][M0_TFT_BIT] |=> panel_format == ($past(regs_reg[IDX_MODE0][0])
        ? LCDC_FMT_TFT_12 : LCDC_FMT_TFT_9))
        else $error("active panel width decoded wrongly");

    chk_mclk_fast: assert property (@(posedge mclk) disable iff (!resetn) // [RL11]
        regs_reg[IDX_MODE1][M1_HIGH_PERF_BIT] |=> mclk_divisor == 4'h1)
        else $error("fast mode memory clock not equal to pixel clock");

    chk_power_decode: assert property (@(posedge mclk) disable iff (!resetn) // [RL12]
        regs_reg[IDX_POWER][1:0] == 2'b11 |=> normal_operation && !power_save_mode1)
        else $error("normal operation not decoded");

    chk_scratch_echo: assert property (@(posedge mclk) disable iff (!resetn) // [RL14]
        wr_done && in_window && idx == IDX_SCRATCH
        |=> regs_reg[IDX_SCRATCH] == $past(avs_writedata[7:0]))
        else $error("scratch byte did not store the written value");

    chk_palette_low: assert property (@(posedge mclk) disable iff (!resetn) // [RL18]
        rd_done && in_window && idx == IDX_PAL_VALUE |-> avs_readdata[3:0] == 4'h0)
        else $error("palette value low nibble not zero");

    chk_height_high: assert property (@(posedge mclk) disable iff (!resetn) // [RL13]
        rd_done && in_window && idx == IDX_S1_HEIGHT_HI |-> avs_readdata[7:2] == 6'h00)
        else $error("height high register unused bits not zero");

    chk_fmt_mono8: assert property (@(posedge mclk) disable iff (!resetn) // [RL5]
        regs_reg[IDX_MODE0][7:5] == 3'b000 && regs_reg[IDX_MODE0][1:0] == 2'b01
        |=> panel_format == LCDC_FMT_MONO_8)
        else $error("mono single 8-bit format not selected");

    chk_fmt_color4: assert property (@(posedge mclk) disable iff (!resetn) // [RL6]
        regs_reg[IDX_MODE0][7:5] == 3'b001 && regs_reg[IDX_MODE0][1:0] == 2'b00
        |=> panel_format == LCDC_FMT_COLOR_4)
        else $error("colour single 4-bit format not selected");

    chk_fmt_dual: assert property (@(posedge mclk) disable iff (!resetn) // [RL9]
        regs_reg[IDX_MODE0][7:6] == 2'b01 && regs_reg[IDX_MODE0][1:0] == 2'b01
        |=> panel_format == ($past(regs_reg[IDX_MODE0][M0_COLOR_BIT])
        ? LCDC_FMT_COLOR_DUAL_8 : LCDC_FMT_MONO_DUAL_8))
        else $error("dual 8-bit format not selected");

    chk_mclk_div: assert property (@(posedge mclk) disable iff (!resetn) // [RL11]
        !regs_reg[IDX_MODE1][M1_HIGH_PERF_BIT]
        |=> 8'(mclk_divisor) * 8'(bits_per_pixel) == 8'h08)
        else $error("memory clock ratio does not match the depth");

    chk_pin_input: assert property (@(posedge mclk) disable iff (!resetn) // [RL16]
        rd_done && in_window && idx == IDX_PIN_LEVEL
        |-> avs_readdata[GPIO_COUNT-1:0] == (($past(gpio_in) & ~gpio_oe) | (gpio_out & gpio_oe)))
        else $error("pin level read does not follow pin directions");

    chk_line_bytes: assert property (@(posedge mclk) disable iff (!resetn) // [RL17]
        wr_done && in_window && idx == IDX_BYTES_LINE
        |=> bytes_per_line == $past(avs_writedata[7:0]))
        else $error("line byte count did not store the written value");
endmodule

// file: dv/lcdc_host_model.sv
// Avalon-MM host model that issues single register transfers to the bank.
`timescale 1ns/1ps
module lcdc_host_model
    import lcdc_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_writedata,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = '0;
    end

    // Holds the request until waitrequest is seen low or 20 cycles pass, then releases it.
    // Released address and data lines show the inverse, never the last value.
    task automatic xfer(input logic [ADDR_W-1:0] addr, input logic is_wr,
        input logic [DATA_W-1:0] wd, input logic [3:0] be,
        output logic [DATA_W-1:0] rd, output logic ok);
        int n;
        @(posedge mclk);
        avs_address <= addr;
        avs_read <= !is_wr;
        avs_write <= is_wr;
        avs_byteenable <= be;
        avs_writedata <= wd;
        ok = 1'b0;
        rd = '0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) begin
                ok = 1'b1;
                rd = avs_readdata;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~addr;
        avs_writedata <= ~wd;
    endtask
endmodule

// file: dv/test_lcdc_config_regs.sv
// Self-checking testbench of the panel controller register bank.
`timescale 1ns/1ps
module test_lcdc_config_regs
    import lcdc_pkg::*;
;
    localparam logic [5:0] PCODE = 6'h15; // Arbitrary value.
    localparam logic [1:0] RCODE = 2'h2; // Arbitrary value.
    logic mclk, resetn, avs_read, avs_write, avs_waitrequest, vblank_status;
    logic [ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [4:0] gpio_in, gpio_out, gpio_oe;
    logic [3:0] bits_per_pixel, mclk_divisor, palette_value;
    logic depth_reserved, power_save_mode1, normal_operation, line_pulse_polarity;
    logic frame_pulse_polarity, pixel_shift_clock_mask, display_blank, panel_power_override;
    lcdc_fmt_e panel_format;
    logic [6:0] horizontal_size;
    logic [9:0] vertical_size, screen1_height;
    logic [15:0] screen1_start, screen2_start;
    logic [7:0] line_offset, palette_index, bytes_per_line;
    logic [7:0] regm [32];
    logic [31:0] seed = 32'h0000_7f51;
    int n_fail = 0;
    int check_count = 0;

    lcdc_config_regs #(.GPIO_COUNT(5), .PRODUCT_CODE(PCODE), .REVISION_CODE(RCODE))
        u_lcdc_config_regs (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .vblank_status(vblank_status),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .bits_per_pixel(bits_per_pixel), .depth_reserved(depth_reserved),
        .panel_format(panel_format), .mclk_divisor(mclk_divisor),
        .power_save_mode1(power_save_mode1), .normal_operation(normal_operation),
        .line_pulse_polarity(line_pulse_polarity), .frame_pulse_polarity(frame_pulse_polarity),
        .pixel_shift_clock_mask(pixel_shift_clock_mask), .display_blank(display_blank),
        .panel_power_override(panel_power_override), .horizontal_size(horizontal_size),
        .vertical_size(vertical_size), .screen1_start(screen1_start),
        .screen2_start(screen2_start), .line_offset(line_offset),
        .screen1_height(screen1_height), .palette_index(palette_index),
        .palette_value(palette_value), .bytes_per_line(bytes_per_line));

    lcdc_host_model u_lcdc_host_model (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] exp_rd(input int i);
        logic [7:0] v;
        v = regm[i];
        if (!REG_MAPPED[i]) v = 8'h00;
        else if (i == 0) v = {PCODE, RCODE};
        else if (i == 10) v[7] = vblank_status;
        else if (i == 25) v = (regm[25] & regm[24]) | ({3'b000, gpio_in} & ~regm[24]);
        return {24'h00_0000, v};
    endfunction

    function automatic lcdc_fmt_e exp_fmt(input logic [7:0] m);
        if (m[7]) return m[0] ? LCDC_FMT_TFT_12 : LCDC_FMT_TFT_9;
        if (m[6]) begin
            if (m[1:0] != 2'b01) return LCDC_FMT_RESERVED;
            return m[5] ? LCDC_FMT_COLOR_DUAL_8 : LCDC_FMT_MONO_DUAL_8;
        end
        if (!m[5] && m[1:0] == 2'b00) return LCDC_FMT_MONO_4;
        if (!m[5] && m[1:0] == 2'b01) return LCDC_FMT_MONO_8;
        if (m[5] && m[1:0] == 2'b00) return LCDC_FMT_COLOR_4;
        if (m[5] && m[1:0] == 2'b01) return LCDC_FMT_COLOR_8_F1;
        if (m[5] && m[1:0] == 2'b11) return LCDC_FMT_COLOR_8_F2;
        return LCDC_FMT_RESERVED;
    endfunction

    task automatic check_outs();
        logic [1:0] d;
        logic res;
        d = regm[2][7:6];
        res = !regm[1][5] && d == 2'b11;
        check(panel_format, exp_fmt(regm[1]));
        check(depth_reserved, res);
        if (!res) check(bits_per_pixel, 4'd1 << d);
        check(mclk_divisor, regm[2][5] ? 4'd1 : 4'd8 >> d);
        check({power_save_mode1, normal_operation},
            {regm[3][1:0] == 2'b00, regm[3][1:0] == 2'b11});
        check({line_pulse_polarity, frame_pulse_polarity, pixel_shift_clock_mask,
            display_blank, panel_power_override}, {regm[1][4:2], regm[2][3], regm[3][3]});
        check(vertical_size, {regm[6][1:0], regm[5]});
        check(screen1_height, {regm[19][1:0], regm[18]});
        check({gpio_oe, gpio_out}, {regm[24][4:0], regm[25][4:0]});
        check({palette_value, palette_index, bytes_per_line},
            {regm[23][7:4], regm[21], regm[28]});
        check({screen1_start, screen2_start}, {regm[13], regm[12], regm[15], regm[14]});
        check({horizontal_size, line_offset}, {regm[4][6:0], regm[17]});
    endtask

    // One transfer; writes update the model, reads are compared with it.
    task automatic op(input logic is_wr, input int i, input logic [7:0] d,
        input logic [3:0] be, input logic win);
        logic [31:0] r, e;
        logic ok;
        u_lcdc_host_model.xfer({(win ? 12'hfff : 12'h000), i[4:0]}, is_wr,
            {24'hff_ffff, d}, be, r, ok);
        if (!ok) begin
            n_fail++;
            report_and_stop();
        end
        if (!is_wr) begin
            // Pin and status inputs may change just before the call, so expect afterwards.
            e = win ? exp_rd(i) : 32'h0000_0000;
            check(r, e);
        end else begin
            if (win && be[0] && REG_MAPPED[i]) regm[i] = d & WR_MASK[i];
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            check_outs();
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int i;
        logic [31:0] r;
        resetn = 1'b0;
        vblank_status = 1'b0;
        gpio_in = 5'h00;
        for (i = 0; i < 32; i++) regm[i] = 8'h00;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (i = 0; i < 32; i++) op(1'b0, i, 8'h00, 4'h0, 1'b1);
        for (i = 0; i < 256; i++) op(1'b1, 1, i[7:0], 4'h1, 1'b1);
        for (i = 0; i < 256; i++) begin
            op(1'b1, 1, {2'b00, i[0], 5'h00}, 4'h1, 1'b1);
            op(1'b1, 2, i[7:0], 4'h1, 1'b1);
        end
        for (i = 0; i < 16; i++) op(1'b1, 3, i[7:0], 4'h1, 1'b1);
        for (i = 0; i < 400; i++) begin
            r = rnd();
            @(posedge mclk);
            gpio_in <= r[4:0];
            vblank_status <= r[5];
            op(r[6], int'(r[12:8]), r[23:16], r[27:24], r[30:28] != 3'b000);
        end
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        for (i = 0; i < 32; i++) regm[i] = 8'h00;
        @(negedge mclk);
        check_outs();
        for (i = 0; i < 32; i++) op(1'b0, i, 8'h00, 4'h0, 1'b1);
        report_and_stop();
    end
endmodule
